// [src/adcsr_top.v]
// How it works
// - sync rise in normal mode forces all ready clocks low while held
// - after sync falls, ready clocks restart after a fixed cycle count
// - sync resets the timing counter and the test pattern generator
// - control register 0x01 bit 10 selects the alternative sync mode
// - alternative mode times from sync fall, ready keeps toggling while high
// - nominal restart delay applies in the high clock band
// - low clock band setting adds one cycle to the restart delay
// - a pulse outside its timing window may be seen one cycle late
// - flashing mode sends one all-ones sample then a run of zeros, repeating
// - flashing zero run is programmable to 10, 11 or 15 samples
// - ramp mode increments and wraps; a sync pulse restarts the ramp
// - all four cores run in step and their ready clocks toggle together
// - every pulse of a repeating sync train resynchronises the device
`include "adcsr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module adcsr_top (
	input wire i_mclk,
	input wire i_nrst,
	input wire i_resync,
	input wire i_spi_sclk,
	input wire i_spi_csn,
	input wire i_spi_mosi,
	output reg o_spi_miso,
	input wire [9:0] i_sample0,
	input wire [9:0] i_sample1,
	input wire [9:0] i_sample2,
	input wire [9:0] i_sample3,
	output reg [9:0] o_data0,
	output reg [9:0] o_data1,
	output reg [9:0] o_data2,
	output reg [9:0] o_data3,
	output reg [3:0] o_ready
);
	localparam ST_RUN = 2'h0;
	localparam ST_HOLD = 2'h1;
	localparam ST_WAIT = 2'h2;

	// synchronisers for pins from outside the clock domain
	reg rs_s1_r;
	reg rs_s2_r;
	reg rs_d_r;
	reg sck_s1_r;
	reg sck_s2_r;
	reg sck_d_r;
	reg csn_s1_r;
	reg csn_s2_r;
	reg mosi_s1_r;
	reg mosi_s2_r;

	reg [15:0] ctrl_r;
	reg [1:0] st_r;
	reg [1:0] st_nxt;
	reg [3:0] cnt_r;
	reg [3:0] cnt_nxt;
	reg rdy_r;
	reg rdy_nxt;
	reg [9:0] ramp_r;
	reg [3:0] fl_r;
	reg [11:0] tmr_r;
	reg [22:0] sh_r;
	reg [4:0] bit_r;
	reg [15:0] tx_r;

	wire rs_rise;
	wire rs_fall;
	wire sck_rise;
	wire sck_fall;
	wire falling_edge_resync_select;
	wire [1:0] tmode;
	wire [3:0] dly;
	wire [3:0] zlen;
	wire run_nxt;
	reg [9:0] pat;
	wire [15:0] stat;
	reg [15:0] rd_word;
	wire [6:0] rx_addr;

	// edge detectors on the synchronised pins; idle levels match the reset values
	assign rs_rise = rs_s2_r & ~rs_d_r;
	assign rs_fall = ~rs_s2_r & rs_d_r;
	assign sck_rise = sck_s2_r & ~sck_d_r;
	assign sck_fall = ~sck_s2_r & sck_d_r;
	assign falling_edge_resync_select = ctrl_r[`ADCSR_FALL_SEL_BIT];
	// test mode selects what replaces the samples
	assign tmode = ctrl_r[`ADCSR_TMODE_MSB:`ADCSR_TMODE_LSB];
	// high band uses the nominal count, low band one more
	assign dly = `ADCSR_RESTART_CYC + {3'h0, ctrl_r[`ADCSR_LOWBAND_BIT]};
	assign run_nxt = (st_nxt == ST_RUN);
	// status: sample timer, spare zero, ready level, sequencer state
	assign stat = {tmr_r, 1'b0, rdy_r, st_r};
	// command address: six bits already shifted plus the bit arriving now
	assign rx_addr = {sh_r[5:0], mosi_s2_r};

	function [3:0] zrun;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: zrun = `ADCSR_ZRUN_10;
				2'h1: zrun = `ADCSR_ZRUN_11;
				default: zrun = `ADCSR_ZRUN_15;
			endcase
		end
	endfunction

	assign zlen = zrun(ctrl_r[`ADCSR_ZLEN_MSB:`ADCSR_ZLEN_LSB]);

	// pattern word for the sample about to leave
	always @* begin
		pat = 10'h000;
		case (tmode)
			`ADCSR_TM_RAMP: begin
				pat = ramp_r;
			end
			`ADCSR_TM_FLASH: begin
				if (fl_r == 4'h0) begin
					pat = 10'h3ff;
				end
			end
			default: begin
				pat = 10'h000;
			end
		endcase
	end

	function [9:0] pick;
		input en;
		input [1:0] mode;
		input [9:0] p;
		input [9:0] s;
		begin
			if (en && (mode == `ADCSR_TM_RAMP || mode == `ADCSR_TM_FLASH)) begin
				pick = p;
			end else begin
				pick = s;
			end
		end
	endfunction

	// restart sequencer
	always @* begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rdy_nxt = rdy_r;
		case (st_r)
			ST_RUN: begin
				if (!falling_edge_resync_select && rs_rise) begin
					st_nxt = ST_HOLD;
					rdy_nxt = 1'b0;
				end else if (falling_edge_resync_select && rs_fall) begin
					st_nxt = ST_WAIT;
					cnt_nxt = dly;
					rdy_nxt = 1'b0;
				end else begin
					rdy_nxt = ~rdy_r;
				end
			end
			ST_HOLD: begin
				rdy_nxt = 1'b0;
				if (!rs_s2_r) begin
					st_nxt = ST_WAIT;
					cnt_nxt = dly;
				end
			end
			ST_WAIT: begin
				rdy_nxt = 1'b0;
				// a new pulse during the wait starts the restart over
				if (!falling_edge_resync_select && rs_rise) begin
					st_nxt = ST_HOLD;
				end else if (falling_edge_resync_select && rs_fall) begin
					cnt_nxt = dly;
				end else if (cnt_r <= 4'h1) begin
					st_nxt = ST_RUN;
					rdy_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			default: begin
				st_nxt = ST_WAIT;
				cnt_nxt = dly;
				rdy_nxt = 1'b0;
			end
		endcase
	end

	// one synchroniser path serves all four lanes so they stay in step
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			rs_s1_r <= 1'b0;
			rs_s2_r <= 1'b0;
			rs_d_r <= 1'b0;
			st_r <= ST_WAIT;
			cnt_r <= `ADCSR_RESTART_CYC;
			rdy_r <= 1'b0;
			o_ready <= 4'h0;
			ramp_r <= 10'h000;
			fl_r <= 4'h0;
			tmr_r <= 12'h000;
			o_data0 <= 10'h000;
			o_data1 <= 10'h000;
			o_data2 <= 10'h000;
			o_data3 <= 10'h000;
		end else begin
			// a pulse landing late is simply seen on the next edge
			rs_s1_r <= i_resync;
			rs_s2_r <= rs_s1_r;
			rs_d_r <= rs_s2_r;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
			o_ready <= {4{rdy_nxt}};
			if (run_nxt) begin
				tmr_r <= tmr_r + 12'h001;
				ramp_r <= ramp_r + 10'h001;
				fl_r <= (fl_r == zlen) ? 4'h0 : fl_r + 4'h1;
				o_data0 <= pick(ctrl_r[`ADCSR_CHEN_LSB], tmode, pat, i_sample0);
				o_data1 <= pick(ctrl_r[`ADCSR_CHEN_LSB + 1], tmode, pat, i_sample1);
				o_data2 <= pick(ctrl_r[`ADCSR_CHEN_LSB + 2], tmode, pat, i_sample2);
				o_data3 <= pick(ctrl_r[`ADCSR_CHEN_MSB], tmode, pat, i_sample3);
			end else begin
				// held or restarting: timers and pattern back to start
				tmr_r <= 12'h000;
				ramp_r <= 10'h000;
				fl_r <= 4'h0;
			end
		end
	end

	// serial control port, mode 0, msb first
	// unmapped addresses read back as zero
	always @* begin
		case (rx_addr)
			`ADCSR_ADDR_CTRL: begin
				rd_word = ctrl_r;
			end
			`ADCSR_ADDR_STAT: begin
				rd_word = stat;
			end
			default: begin
				rd_word = 16'h0000;
			end
		endcase
	end

	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_d_r <= 1'b0;
			csn_s1_r <= 1'b1;
			csn_s2_r <= 1'b1;
			mosi_s1_r <= 1'b0;
			mosi_s2_r <= 1'b0;
			sh_r <= 23'h000000;
			bit_r <= 5'h00;
			tx_r <= 16'h0000;
			o_spi_miso <= 1'b0;
			ctrl_r <= `ADCSR_CTRL_RST;
		end else begin
			sck_s1_r <= i_spi_sclk;
			sck_s2_r <= sck_s1_r;
			sck_d_r <= sck_s2_r;
			csn_s1_r <= i_spi_csn;
			csn_s2_r <= csn_s1_r;
			mosi_s1_r <= i_spi_mosi;
			mosi_s2_r <= mosi_s1_r;
			if (csn_s2_r) begin
				bit_r <= 5'h00;
				tx_r <= 16'h0000;
				o_spi_miso <= 1'b0;
			end else begin
				if (sck_rise) begin
					sh_r <= {sh_r[21:0], mosi_s2_r};
					bit_r <= bit_r + 5'h01;
					if (bit_r == `ADCSR_CMD_BITS - 5'h01 && sh_r[6]) begin
						tx_r <= rd_word;
					end
					if (bit_r == `ADCSR_FRAME_BITS - 5'h01 && !sh_r[22]
						&& sh_r[21:15] == `ADCSR_ADDR_CTRL) begin
						ctrl_r <= {sh_r[14:0], mosi_s2_r};
					end
				end else if (sck_fall && bit_r >= `ADCSR_CMD_BITS) begin
					o_spi_miso <= tx_r[15];
					tx_r <= {tx_r[14:0], 1'b0};
				end
			end
		end
	end
endmodule
`default_nettype wire

// [pkg/adcsr_defines.vh]
`ifndef ADCSR_DEFINES_VH
`define ADCSR_DEFINES_VH
// register addresses on the serial port
`define ADCSR_ADDR_CTRL 7'h01
`define ADCSR_ADDR_STAT 7'h02
`define ADCSR_CTRL_RST 16'hf000
// control register fields
`define ADCSR_TMODE_LSB 0
`define ADCSR_TMODE_MSB 1
`define ADCSR_ZLEN_LSB 2
`define ADCSR_ZLEN_MSB 3
`define ADCSR_LOWBAND_BIT 4
`define ADCSR_FALL_SEL_BIT 10
`define ADCSR_CHEN_LSB 12
`define ADCSR_CHEN_MSB 15
// test mode codes
`define ADCSR_TM_NORMAL 2'h0
`define ADCSR_TM_RAMP 2'h1
`define ADCSR_TM_FLASH 2'h2
// flashing zero-run lengths
`define ADCSR_ZRUN_10 4'ha
`define ADCSR_ZRUN_11 4'hb
`define ADCSR_ZRUN_15 4'hf
// restart delay in sampling clock cycles after the release is seen
`define ADCSR_RESTART_CYC 4'h4
// serial frame: 1 rw bit, 7 address bits, 16 data bits
`define ADCSR_CMD_BITS 5'h08
`define ADCSR_FRAME_BITS 5'h18
`endif

// [verification/adcsr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module adcsr_monitor(
	input wire i_mclk,
	input wire i_nrst,
	input wire i_resync,
	input wire i_spi_sclk,
	input wire i_spi_csn,
	input wire o_spi_miso,
	input wire [9:0] o_data0,
	input wire [3:0] o_ready
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	reg [3:0] idle_r;
	// cycles with ready and sync both low
	always @(posedge i_mclk) begin
		if (!i_nrst || o_ready != 4'h0 || i_resync)
			idle_r <= 4'h0;
		else if (idle_r != 4'hf)
			idle_r <= idle_r + 4'h1;
	end
	a_ready_lockstep: assert property (o_ready == 4'h0 || o_ready == 4'hf) else $error("ready lanes");
	a_ready_toggle: assert property (o_ready[0] |=> !o_ready[0]) else $error("ready high");
	a_wait_low: assert property ($fell(i_resync) |-> ##4 (o_ready == 4'h0)[*3]) else $error("early");
	a_restart_bound: assert property ($fell(i_resync) |-> ##[5:10] o_ready[0]) else $error("late");
	a_no_stall: assert property (idle_r < 4'ha) else $error("stalled");
	a_data_frozen: assert property ((o_ready == 4'h0)[*3] |-> $stable(o_data0)) else $error("data");
	a_miso_idle: assert property (i_spi_csn[*4] |-> !o_spi_miso) else $error("miso idle");
	a_miso_launch: assert property ($changed(o_spi_miso) |-> !i_spi_sclk || i_spi_csn) else $error("miso");
	c_restart: cover property ($fell(i_resync) ##7 o_ready[0]);
	c_hold: cover property (i_resync[*6] ##0 o_ready == 4'h0);
	c_read: cover property (!i_spi_csn && o_spi_miso);
endmodule
bind adcsr_top adcsr_monitor mon_u(.i_mclk, .i_nrst, .i_resync, .i_spi_sclk, .i_spi_csn, .o_spi_miso, .o_data0, .o_ready);
`default_nettype wire

// [verification/adcsr_fpga_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcsr_fpga_model(
	input wire logic i_mclk,
	input wire logic i_miso,
	output logic o_resync = 1'b0,
	output logic o_sclk = 1'b0,
	output logic o_csn = 1'b1,
	output logic o_mosi = 1'b0
);
	// sync moves on the clock edge so it meets its window
	task automatic pulse(input int n);
		o_resync <= 1'b1;
		repeat (n) @(posedge i_mclk);
		o_resync <= 1'b0;
	endtask
	// sclk still between frames, mosi flipped once released
	task automatic xfer(input [23:0] f, output [15:0] rd);
		rd = 16'h0;
		o_csn <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_mosi <= f[i];
			repeat (4) @(posedge i_mclk);
			o_sclk <= 1'b1;
			rd = {rd[14:0], i_miso};
			repeat (4) @(posedge i_mclk);
			o_sclk <= 1'b0;
		end
		o_csn <= 1'b1;
		o_mosi <= ~o_mosi;
		repeat (4) @(posedge i_mclk);
	endtask
endmodule
`default_nettype wire

// [verification/adc_sync_reset_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_sync_reset_control_tb;
	logic i_mclk = 0;
	logic i_nrst = 0;
	logic [9:0] i_sample0 = 0, i_sample1 = 0, i_sample2 = 0, i_sample3 = 0;
	wire i_resync, i_spi_sclk, i_spi_csn, i_spi_mosi, o_spi_miso;
	wire [9:0] o_data0, o_data1, o_data2, o_data3;
	wire [3:0] o_ready;
	integer seed = 32'h7496, mismatches = 0, checks = 0, cyc = 0, k;
	reg [15:0] rd;
	reg [9:0] s;
	reg [1:0] z;
	adcsr_fpga_model fpga_u(.i_mclk, .i_miso(o_spi_miso), .o_resync(i_resync), .o_sclk(i_spi_sclk),
		.o_csn(i_spi_csn), .o_mosi(i_spi_mosi));
	adcsr_top dut_u(.i_mclk, .i_nrst, .i_resync, .i_spi_sclk, .i_spi_csn, .i_spi_mosi, .o_spi_miso,
		.i_sample0, .i_sample1, .i_sample2, .i_sample3, .o_data0, .o_data1, .o_data2, .o_data3, .o_ready);
	always #12.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		{i_sample0, i_sample1} <= 20'($random(seed));
		{i_sample2, i_sample3} <= 20'($random(seed));
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			end_of_test;
		end
	end
	// three synchroniser edges, four wait cycles, one read lag
	function [15:0] exp_dly(input bit lb);
		return 16'h8 + lb;
	endfunction
	function [9:0] flash(input int i);
		return i % (z == 0 ? 11 : z == 1 ? 12 : 16) ? 10'h0 : 10'h3ff;
	endfunction
	task chk(input [15:0] got, input [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [15:0] v);
		fpga_u.xfer({8'h01, v}, rd);
		fpga_u.xfer(24'h810000, rd);
		chk(rd, v);
	endtask
	task sync_dly(input int n, input bit falling_edge_resync_select);
		reg [3:0] h;
		fpga_u.pulse(n);
		h = o_ready;
		@(posedge i_mclk);
		chk({12'h0, h ^ o_ready}, {12'h0, {4{falling_edge_resync_select}}});
		if (!falling_edge_resync_select) chk({12'h0, h}, 16'h0);
		k = 1;
		do begin
			@(posedge i_mclk);
			k = k + 1;
		end while ((k < 4 || !o_ready[0]) && k < 40);
	endtask
	task pat(input bit ramp, input int n);
		reg [9:0] e;
		for (int i = 0; i < n; i++) begin
			e = ramp ? i[9:0] : flash(i);
			chk({6'h0, o_data1}, {6'h0, e});
			chk({6'h0, o_data3}, {6'h0, e});
			chk({6'h0, o_data2}, {6'h0, e});
			if (i > 0) chk({6'h0, o_data0}, {6'h0, s});
			s = i_sample0;
			@(posedge i_mclk);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		i_nrst <= 1;
		repeat (4) @(posedge i_mclk);
		fpga_u.xfer(24'h810000, rd);
		chk(rd, 16'hf000);
		fpga_u.xfer(24'h850000, rd);
		chk(rd, 16'h0);
		for (int i = 0; i < 6; i++) begin
			wr(16'hf000 | {5'h0, i[0], 5'h0, i[1], 4'h0});
			sync_dly(5 + i, i[0]);
			chk(k[15:0], exp_dly(i[1]));
		end
		for (int j = 0; j < 5; j++) begin
			z = j[1:0] - 2'h2;
			wr(j < 2 ? 16'he001 : {12'he00, z, 2'h2});
			sync_dly(6, 0);
			pat(j < 2, j ? 60 : 1030);
		end
		end_of_test;
	end
endmodule
`default_nettype wire
